// File: rtl/ext_ctrl_pkg.sv
// package for the external status command interpreter
// assumes a 125 MHz system clock; durations are held in seconds
package ext_ctrl_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam logic [15:0] EXTERNAL_COMMAND_WORD_ADDR = 16'h1770;
  localparam logic [3:0] STATUS_AUTO = 4'h0;
  localparam logic [3:0] STATUS_LAST_POINT = 4'ha;
  localparam logic [3:0] STATUS_ALARM_RESET = 4'he;
  localparam logic [3:0] SINGLE_OFFSET_MA = 4'h4;
  localparam logic [4:0] SINGLE_MAX_MA = 5'h13;
  localparam logic [4:0] THRESHOLD_MA = 5'h0b;
  localparam logic [3:0] POINTS_RESET = 4'ha;
  localparam logic [11:0] ZERO_TIME_RESET = 12'h12c;
  localparam logic [11:0] SUCTION_TIME_RESET = 12'h03c;
  localparam logic [11:0] PURGE_TIME_RESET = 12'h03c;

  typedef enum logic [2:0] {
    SRC_OFF,
    SRC_RELAY,
    SRC_FOUR_CURRENT,
    SRC_ONE_CURRENT,
    SRC_BUS
  } source_t;

  typedef enum logic [2:0] {
    PH_AUTO,
    PH_ZERO,
    PH_SAMPLE,
    PH_MEASURE,
    PH_PURGE,
    PH_IDLE
  } phase_t;

  typedef struct packed {
    logic [11:0] zero_s;
    logic [11:0] suction_s;
    logic [11:0] purge_s;
  } durations_t;

  typedef struct packed {
    logic [9:0] point_valve;
    logic zero_valve;
    logic pump_on;
  } valves_t;
endpackage

// File: rtl/status_decoder.sv
// decodes the selected source into a 4-bit status number
// assumes all inputs already synchronised to clk_i
`timescale 1ns/10ps
`default_nettype none
module status_decoder (
  // source select
  input wire ext_ctrl_pkg::source_t source_i,
  // raw inputs, current in mA
  input wire logic [3:0] relay_i,
  input wire logic [4:0] line_in_1_ma_i,
  input wire logic [4:0] line_in_2_ma_i,
  input wire logic [4:0] line_in_3_ma_i,
  input wire logic [4:0] line_in_4_ma_i,
  input wire logic [3:0] bus_value_i,
  // result
  output logic [3:0] status_o
);
  logic [3:0] single;
  always_comb begin
    // below offset clamps to 0, above top clamps to 15
    if (line_in_1_ma_i <= {1'b0, ext_ctrl_pkg::SINGLE_OFFSET_MA}) begin
      single = 4'h0;
    end else if (line_in_1_ma_i > ext_ctrl_pkg::SINGLE_MAX_MA) begin
      single = 4'hf;
    end else begin
      single = 4'(line_in_1_ma_i - {1'b0, ext_ctrl_pkg::SINGLE_OFFSET_MA}); // RULE7
    end
  end

  always_comb begin
    case (source_i) // RULE9
      ext_ctrl_pkg::SRC_RELAY: status_o = relay_i;
      ext_ctrl_pkg::SRC_FOUR_CURRENT: status_o = {
        line_in_4_ma_i >= ext_ctrl_pkg::THRESHOLD_MA,
        line_in_3_ma_i >= ext_ctrl_pkg::THRESHOLD_MA,
        line_in_2_ma_i >= ext_ctrl_pkg::THRESHOLD_MA,
        line_in_1_ma_i >= ext_ctrl_pkg::THRESHOLD_MA}; // RULE1 RULE2
      ext_ctrl_pkg::SRC_ONE_CURRENT: status_o = single; // RULE7
      ext_ctrl_pkg::SRC_BUS: status_o = bus_value_i; // RULE8
      default: status_o = 4'h0;
    endcase
  end
endmodule // status_decoder
`default_nettype wire

// File: rtl/ext_ctrl.sv
// external status command interpreter: source decode and phase sequencing
// assumes pin-side current and relay inputs are asynchronous, bus write is on clk_i
// What this block does
// RULE1: four-input mode builds status from line_in_4 down to line_in_1.
// RULE2: each current reads zero below 11 mA, one from 11 to 20 mA.
// RULE3: status zero leaves the analyzer on its own automatic cycle.
// RULE4: status 1 to 10 samples that point if it is installed.
// RULE5: status 11,12,13,15 or above installed count means stand-by.
// RULE6: status 14 resets all active system alarms.
// RULE7: single-input mode: status is current minus 4 mA, 1 mA steps.
// RULE8: bus master writes status to holding register 6000, same encoding.
// RULE9: a source select picks off, relay, four current, one current or bus.
// RULE10: nonzero status raises external-control indicator and holds command.
// RULE11: zeroing, suction and purge durations are programmable and time phases.
// RULE12: stand-by purges for purge time, then valves closed, pump off, idle.
// RULE13: leaving stand-by runs zeroing, then measures the selected point.
// RULE14: selected point runs zeroing, then sampling, then measurement.
// RULE15: measurement runs until the status number changes to a code other than 14.
// RULE16: any change of selected point is preceded by a zeroing.
// RULE17: controller forces zeroing with ten seconds of stand-by, one hour max.
// RULE18: status registered each clock; a change restarts the sequencing, except a change to 14 or to a stand-by code during purge or idle.
`timescale 1ns/10ps
`default_nettype none
module ext_ctrl #(
  parameter int unsigned TICK_CYCLES = ext_ctrl_pkg::TICK_CYCLES,
  parameter int unsigned MAX_POINTS = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire ext_ctrl_pkg::source_t source_i,
  input wire logic [3:0] points_installed_i,
  input wire ext_ctrl_pkg::durations_t durations_i,
  // pin inputs, asynchronous
  input wire logic [3:0] relay_i,
  input wire logic [4:0] line_in_1_ma_i,
  input wire logic [4:0] line_in_2_ma_i,
  input wire logic [4:0] line_in_3_ma_i,
  input wire logic [4:0] line_in_4_ma_i,
  // register write port
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  // status and actuators
  output logic [3:0] status_o,
  output logic ext_active_o,
  output ext_ctrl_pkg::phase_t phase_o,
  output logic [3:0] point_o,
  output ext_ctrl_pkg::valves_t valves_o,
  output logic alarm_reset_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // two-flop synchronisers for pin inputs
  logic [23:0] meta, sync;
  logic [23:0] pins;
  assign pins = {relay_i, line_in_1_ma_i, line_in_2_ma_i, line_in_3_ma_i, line_in_4_ma_i};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pins;
      sync <= meta;
    end
  end

  // command word register
  logic [15:0] cmd_word, next_cmd_word;
  always_comb begin
    next_cmd_word = cmd_word;
    if (reg_wr_i && reg_addr_i == ext_ctrl_pkg::EXTERNAL_COMMAND_WORD_ADDR) begin
      next_cmd_word = reg_wdata_i; // RULE8
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_word <= '0;
    end else begin
      cmd_word <= next_cmd_word;
    end
  end

  // decode
  logic [3:0] decoded;
  status_decoder u_dec (
    .source_i(source_i),
    .relay_i(sync[23:20]),
    .line_in_1_ma_i(sync[19:15]),
    .line_in_2_ma_i(sync[14:10]),
    .line_in_3_ma_i(sync[9:5]),
    .line_in_4_ma_i(sync[4:0]),
    .bus_value_i(cmd_word[15:4] == 12'h000 ? cmd_word[3:0] : 4'hf),
    .status_o(decoded)
  );

  // classification of a status number
  function automatic logic is_standby(input logic [3:0] s, input logic [3:0] n);
    logic over;
    over = (s > n) || (s > ext_ctrl_pkg::STATUS_LAST_POINT);
    is_standby = (s != ext_ctrl_pkg::STATUS_ALARM_RESET)
      && (s != ext_ctrl_pkg::STATUS_AUTO) && over; // RULE5
  endfunction

  // sequencer state
  ext_ctrl_pkg::phase_t phase, next_phase;
  logic [3:0] status, next_status;
  logic [3:0] point, next_point;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic [11:0] sec_cnt, next_sec_cnt;
  logic active, next_active;
  logic alarm_pulse, next_alarm_pulse;
  ext_ctrl_pkg::valves_t valves, next_valves;
  logic [3:0] n_pts;
  logic changed, sec_tick, expired;

  assign n_pts = (points_installed_i > 4'(MAX_POINTS)) ? 4'(MAX_POINTS) : points_installed_i;
  assign changed = decoded != status; // RULE18
  assign sec_tick = tick_cnt == TW'(TICK_CYCLES - 1);
  assign expired = sec_tick && sec_cnt <= 12'h001;

  always_comb begin
    next_status = decoded; // RULE18
    next_phase = phase;
    next_point = point;
    next_tick_cnt = sec_tick ? '0 : tick_cnt + TW'(1);
    next_sec_cnt = (sec_tick && sec_cnt != 12'h000) ? sec_cnt - 12'h001 : sec_cnt;
    next_active = decoded != ext_ctrl_pkg::STATUS_AUTO; // RULE10
    next_alarm_pulse = 1'b0;
    if (changed) begin
      next_tick_cnt = '0;
      if (decoded == ext_ctrl_pkg::STATUS_ALARM_RESET) begin
        next_alarm_pulse = 1'b1; // RULE6
      end else if (decoded == ext_ctrl_pkg::STATUS_AUTO) begin
        next_phase = ext_ctrl_pkg::PH_AUTO; // RULE3
        next_point = 4'h0;
      end else if (is_standby(decoded, n_pts)) begin
        if (phase != ext_ctrl_pkg::PH_PURGE && phase != ext_ctrl_pkg::PH_IDLE) begin
          next_phase = ext_ctrl_pkg::PH_PURGE; // RULE12
          next_sec_cnt = durations_i.purge_s; // RULE11
        end
        next_point = 4'h0;
      end else begin
        // new point or return from stand-by: always start with zeroing
        next_phase = ext_ctrl_pkg::PH_ZERO; // RULE4 RULE13 RULE16
        next_point = decoded;
        next_sec_cnt = durations_i.zero_s; // RULE11
      end
    end else begin
      case (phase)
        ext_ctrl_pkg::PH_ZERO: begin
          if (expired) begin
            next_phase = ext_ctrl_pkg::PH_SAMPLE; // RULE14
            next_sec_cnt = durations_i.suction_s;
          end
        end
        ext_ctrl_pkg::PH_SAMPLE: begin
          if (expired) begin
            next_phase = ext_ctrl_pkg::PH_MEASURE; // RULE14
          end
        end
        ext_ctrl_pkg::PH_MEASURE: begin
          next_phase = ext_ctrl_pkg::PH_MEASURE; // RULE15
        end
        ext_ctrl_pkg::PH_PURGE: begin
          if (expired) begin
            next_phase = ext_ctrl_pkg::PH_IDLE; // RULE12
          end
        end
        default: begin
          next_phase = phase;
        end
      endcase
    end
  end

  // actuator outputs follow the next phase
  always_comb begin
    next_valves = '0;
    case (next_phase)
      ext_ctrl_pkg::PH_ZERO: begin
        next_valves.zero_valve = 1'b1;
        next_valves.pump_on = 1'b1;
      end
      ext_ctrl_pkg::PH_SAMPLE, ext_ctrl_pkg::PH_MEASURE: begin
        next_valves.point_valve[next_point - 4'h1] = 1'b1;
        next_valves.pump_on = 1'b1;
      end
      ext_ctrl_pkg::PH_PURGE: begin
        next_valves.zero_valve = 1'b1; // RULE12
        next_valves.pump_on = 1'b1;
      end
      default: begin
        next_valves = '0; // RULE12
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= ext_ctrl_pkg::PH_AUTO;
      status <= ext_ctrl_pkg::STATUS_AUTO;
      point <= 4'h0;
      tick_cnt <= '0;
      sec_cnt <= '0;
      active <= 1'b0;
      alarm_pulse <= 1'b0;
      valves <= '0;
    end else begin
      phase <= next_phase;
      status <= next_status;
      point <= next_point;
      tick_cnt <= next_tick_cnt;
      sec_cnt <= next_sec_cnt;
      active <= next_active;
      alarm_pulse <= next_alarm_pulse;
      valves <= next_valves;
    end
  end

  assign status_o = status;
  assign ext_active_o = active;
  assign phase_o = phase;
  assign point_o = point;
  assign valves_o = valves;
  assign alarm_reset_o = alarm_pulse;
endmodule // ext_ctrl
`default_nettype wire

// File: testbench/ext_ctrl_props.sv
// checker for the external command interpreter
// bound to the ext_ctrl ports from the bench top
`timescale 1ns/10ps
`default_nettype none
module ext_ctrl_props #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned MAX_POINTS = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // watched signals
  input wire logic [3:0] points_installed_i,
  input wire logic [3:0] status_o,
  input wire logic ext_active_o,
  input wire ext_ctrl_pkg::phase_t phase_o,
  input wire logic [3:0] point_o,
  input wire ext_ctrl_pkg::valves_t valves_o,
  input wire logic alarm_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic sby;
  assign sby = (status_o > points_installed_i || status_o > 4'ha) && status_o != 4'he;
  sequence new_point;
    $changed(status_o) && !sby && status_o != 4'h0 && status_o != 4'he;
  endsequence
  sequence new_standby;
    $changed(status_o) && sby && $past(phase_o) != ext_ctrl_pkg::PH_PURGE
      && $past(phase_o) != ext_ctrl_pkg::PH_IDLE;
  endsequence
  a_active_flag: assert property (ext_active_o == (status_o != 4'h0))
    else $error("active flag wrong");
  a_auto_phase: assert property (status_o == 4'h0 |-> phase_o == ext_ctrl_pkg::PH_AUTO)
    else $error("status zero not auto");
  a_point_zeroes: assert property (new_point |-> phase_o == ext_ctrl_pkg::PH_ZERO)
    else $error("new point without zeroing");
  a_standby_purges: assert property (new_standby |-> phase_o == ext_ctrl_pkg::PH_PURGE)
    else $error("standby without purge");
  a_alarm_pulse: assert property (alarm_reset_o |-> status_o == 4'he ##1 !alarm_reset_o)
    else $error("alarm pulse wrong");
  a_sample_order: assert property ($changed(phase_o) && phase_o == ext_ctrl_pkg::PH_SAMPLE
    |-> $past(phase_o) == ext_ctrl_pkg::PH_ZERO)
    else $error("sampling not after zeroing");
  a_measure_order: assert property ($changed(phase_o) && phase_o == ext_ctrl_pkg::PH_MEASURE
    |-> $past(phase_o) == ext_ctrl_pkg::PH_SAMPLE)
    else $error("measuring not after sampling");
  a_measure_holds: assert property (phase_o == ext_ctrl_pkg::PH_MEASURE ##1 $stable(status_o)
    |-> phase_o == ext_ctrl_pkg::PH_MEASURE)
    else $error("measurement aborted");
  a_idle_off: assert property (phase_o == ext_ctrl_pkg::PH_IDLE |-> valves_o == 12'h000)
    else $error("idle with valves or pump on");
  a_point_valve: assert property (phase_o == ext_ctrl_pkg::PH_MEASURE
    |-> (point_o == status_o || status_o == 4'he) && valves_o.point_valve[point_o - 4'h1])
    else $error("wrong point measured");
endmodule // ext_ctrl_props
`default_nettype wire

// File: testbench/remote_ctrl.sv
// remote controller model: pin currents, relays and register writes
// bench sets source, command and write strobe off clk_i
`timescale 1ns/10ps
`default_nettype none
module remote_ctrl (
  // control from bench
  input wire logic clk_i,
  input wire ext_ctrl_pkg::source_t src_i,
  input wire logic [3:0] cmd_i,
  input wire logic wr_i,
  input wire logic bad_i,
  // far-side drive
  output logic [3:0] relay_o,
  output logic [4:0] line_in_1_ma_o,
  output logic [4:0] line_in_2_ma_o,
  output logic [4:0] line_in_3_ma_o,
  output logic [4:0] line_in_4_ma_o,
  output logic reg_wr_o,
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o
);
  logic inv;
  // unselected sources carry the opposite pattern
  assign inv = src_i != ext_ctrl_pkg::SRC_FOUR_CURRENT;
  function automatic logic [4:0] cur(input logic b);
    return b ? 5'h0b : 5'h0a;
  endfunction
  assign relay_o = src_i == ext_ctrl_pkg::SRC_RELAY ? cmd_i : ~cmd_i;
  assign line_in_1_ma_o = src_i == ext_ctrl_pkg::SRC_ONE_CURRENT ?
    {1'b0, cmd_i} + 5'h04 : cur(cmd_i[0] ^ inv);
  assign line_in_2_ma_o = cur(cmd_i[1] ^ inv);
  assign line_in_3_ma_o = cur(cmd_i[2] ^ inv);
  assign line_in_4_ma_o = cur(cmd_i[3] ^ inv);
  always @(posedge clk_i) begin
    reg_wr_o <= wr_i;
    reg_addr_o <= bad_i ? 16'h1771 : 16'h1770;
    reg_wdata_o <= {12'h000, src_i == ext_ctrl_pkg::SRC_BUS ? cmd_i : ~cmd_i};
  end
endmodule // remote_ctrl
`default_nettype wire

// File: testbench/ext_ctrl_tb.sv
// self-checking bench for the external command interpreter
// drives ext_ctrl through the remote controller model, short tick
`timescale 1ns/10ps
`default_nettype none
module ext_ctrl_tb;
  localparam int TICK = 10;
  localparam ext_ctrl_pkg::durations_t DUR = 36'h003002002;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  ext_ctrl_pkg::source_t src = ext_ctrl_pkg::SRC_FOUR_CURRENT;
  logic [3:0] cmd = 4'h0;
  logic [3:0] pts = 4'ha;
  logic [3:0] pe = 4'h0;
  logic wr = 1'b0;
  logic bad = 1'b0;
  // last non-alarm status was a stand-by code
  logic sb = 1'b0;
  logic [3:0] relay, status, point;
  logic [4:0] l1, l2, l3, l4;
  logic reg_wr, active, alarm;
  logic [15:0] reg_addr, reg_wdata;
  ext_ctrl_pkg::phase_t phase;
  ext_ctrl_pkg::valves_t valves;
  int error_cnt = 0;
  int checked = 0;
  int n;
  initial forever #4 clk_i = ~clk_i;
  remote_ctrl far (.clk_i(clk_i), .src_i(src), .cmd_i(cmd), .wr_i(wr), .bad_i(bad),
    .relay_o(relay), .line_in_1_ma_o(l1), .line_in_2_ma_o(l2), .line_in_3_ma_o(l3),
    .line_in_4_ma_o(l4), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  ext_ctrl #(.TICK_CYCLES(TICK)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .source_i(src),
    .points_installed_i(pts), .durations_i(DUR), .relay_i(relay), .line_in_1_ma_i(l1),
    .line_in_2_ma_i(l2), .line_in_3_ma_i(l3), .line_in_4_ma_i(l4), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .status_o(status), .ext_active_o(active),
    .phase_o(phase), .point_o(point), .valves_o(valves), .alarm_reset_o(alarm));
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input logic [3:0] c, input logic b);
    @(posedge clk_i);
    cmd <= c;
    wr <= 1'b1;
    bad <= b;
    @(posedge clk_i);
    wr <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wait_ph(input ext_ctrl_pkg::phase_t p);
    n = 0;
    while (phase !== p && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic judge(input logic [3:0] c);
    logic [3:0] e;
    e = src == ext_ctrl_pkg::SRC_OFF ? 4'h0 : c;
    chk("status", e, status);
    chk("active", e != 4'h0, active);
    if (e != pe && e == 4'h0) chk("auto", ext_ctrl_pkg::PH_AUTO, phase);
    else if (e != pe && e <= pts && e != 4'he) chk("zero", ext_ctrl_pkg::PH_ZERO, phase);
    else if (e != pe && e != 4'he && sb) chk("standby kept", 1,
      phase == ext_ctrl_pkg::PH_PURGE || phase == ext_ctrl_pkg::PH_IDLE);
    else if (e != pe && e != 4'he) chk("standby", 1, phase == ext_ctrl_pkg::PH_PURGE);
    if (e != pe && e != 4'he) sb = e != 4'h0 && (e > pts || e > 4'ha);
    pe = e;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha308));
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk("reset phase", ext_ctrl_pkg::PH_AUTO, phase);
    for (int s = 0; s < 5; s++) begin
      src <= ext_ctrl_pkg::source_t'(s);
      pts <= 4'($urandom_range(10, 1));
      for (int i = 0; i < 24; i++) begin
        cmd <= cmd;
        apply(i < 16 ? 4'(i) : 4'($urandom_range(15, 0)), 1'b0);
        judge(cmd);
      end
    end
    pts <= 4'h4;
    apply(4'h0, 1'b0);
    apply(4'h2, 1'b0);
    wait_ph(ext_ctrl_pkg::PH_SAMPLE);
    chk("zero time", 1, n + 4 >= 3 * TICK && n + 4 <= 3 * TICK + 2);
    wait_ph(ext_ctrl_pkg::PH_MEASURE);
    chk("suction time", 1, n >= TICK && n <= 2 * TICK + 1);
    repeat (100) @(posedge clk_i);
    chk("measuring", ext_ctrl_pkg::PH_MEASURE, phase);
    apply(4'h9, 1'b1);
    chk("bad address", 4'h2, status);
    apply(4'hf, 1'b0);
    wait_ph(ext_ctrl_pkg::PH_IDLE);
    chk("purge time", 1, n + 4 >= 2 * TICK && n + 4 <= 2 * TICK + 2);
    chk("idle valves", 12'h000, valves);
    apply(4'h2, 1'b0);
    chk("rezero", ext_ctrl_pkg::PH_ZERO, phase);
    summarize();
  end
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
endmodule // ext_ctrl_tb
bind ext_ctrl ext_ctrl_props #(.TICK_CYCLES(TICK_CYCLES), .MAX_POINTS(MAX_POINTS)) props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .points_installed_i(points_installed_i),
  .status_o(status_o), .ext_active_o(ext_active_o), .phase_o(phase_o), .point_o(point_o),
  .valves_o(valves_o), .alarm_reset_o(alarm_reset_o));
`default_nettype wire
